// File: rtl/acsr_pkg.sv
// Package with register map, field layout and state types of the channel register bank
package acsr_pkg;
	localparam int NUM_CH = 8;
	localparam int FS_W = 24;
	localparam int INT_W = 11;
	// Register word indices; byte address is four times the index
	localparam logic [7:0] IDX_FS_BASE = 8'h18;
	localparam logic [7:0] IDX_STAT_BASE = 8'h20;
	localparam logic [7:0] IDX_SETUP_BASE = 8'h28;
	localparam logic [7:0] IDX_INT_STAT = 8'h40;
	localparam logic [7:0] IDX_INT_MASK = 8'h41;
	// Values after reset
	localparam logic [FS_W-1:0] FS_RESET = 24'h20_0000;
	localparam logic [7:0] SETUP_RESET = 8'h00;
	// Setup register fields
	localparam int SU_BUF_OFF = 7;
	localparam int SU_CFG_HI = 6;
	localparam int SU_CFG_LO = 5;
	localparam int SU_STATUS_OPTION = 4;
	localparam int SU_ENABLE = 3;
	localparam int SU_RANGE_MSB = 2;
	localparam int SU_RANGE_LSB = 0;
	localparam logic [1:0] CFG_DIFF = 2'h3;
	// Status register fields
	localparam int ST_CHAN_LSB = 5;
	localparam int ST_GPIO0 = 4;
	localparam int ST_READY = 3;
	localparam int ST_MISSING_REFERENCE_FLAG = 2;
	localparam int ST_SIGN = 1;
	localparam int ST_OVR = 0;
	// Interrupt status and mask layout
	localparam int INT_CONV_LSB = 0;
	localparam int INT_MISSING_REFERENCE_FLAG = 8;
	localparam int INT_OVR = 9;
	localparam int INT_CAL = 10;
	// Bus encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HRESP_OKAY = 2'h0;

	typedef struct packed {
		logic [NUM_CH-1:0][FS_W-1:0] fs;
		logic [NUM_CH-1:0][7:0] setup;
		logic [NUM_CH-1:0] ready;
		logic [NUM_CH-1:0] missing_reference_flag;
		logic [NUM_CH-1:0] sign;
		logic [NUM_CH-1:0] out_of_range_flag;
		logic [2:0] g0_sync;
		logic [2:0] g1_sync;
		logic gpio0;
		logic gpio1;
		logic [INT_W-1:0] int_stat;
		logic [INT_W-1:0] int_mask;
		logic wr_pend;
		logic [7:0] wr_idx;
		logic [31:0] rdata;
		logic [NUM_CH-1:0][2:0] mux_pos;
		logic [NUM_CH-1:0][2:0] mux_neg;
		logic [NUM_CH-1:0] mux_common;
		logic [FS_W-1:0] fs_sel;
	} acsr_bank_s;

	localparam acsr_bank_s BANK_RESET = '{
		fs: {NUM_CH{FS_RESET}},
		setup: {NUM_CH{SETUP_RESET}},
		// Routing and coefficient tap match the setup and coefficient reset values
		mux_pos: {3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0},
		mux_neg: {3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0},
		mux_common: {NUM_CH{1'b1}},
		fs_sel: FS_RESET,
		default: '0
	};

	typedef struct packed {
		logic valid;
		logic [2:0] chan;
		logic [7:0] status;
	} acsr_tap_s;
endpackage : acsr_pkg

// File: rtl/acsr_tap_if.sv
// Interface carrying the live channel status bytes from the bank to the read tap
`timescale 1ns/1ns
interface acsr_tap_if;
	logic [acsr_pkg::NUM_CH-1:0][7:0] status_bytes;
	modport bank (
		output status_bytes
	);
	modport tap (
		input status_bytes
	);
endinterface : acsr_tap_if

// File: rtl/acsr_status_tap.sv
// Status byte tap that pairs channel status with channel data transfers
`timescale 1ns/1ns
module acsr_status_tap (
	input wire logic hclk,
	input wire logic hresetn,
	acsr_tap_if.tap tap,
	input wire logic data_read,
	input wire logic [2:0] data_read_chan,
	input wire logic cont_read_mode,
	input wire logic dump_status_en,
	output logic status_out_valid,
	output logic [2:0] status_out_chan,
	output logic [7:0] status_out
);
	acsr_pkg::acsr_tap_s r_reg;
	acsr_pkg::acsr_tap_s r_next;
	logic want;

	always_comb begin
		r_next = r_reg;
		// Continuous read always pairs, dump mode only on request
		want = data_read & (cont_read_mode | dump_status_en); // [RQ11] [RQ12]
		r_next.valid = want;
		if (want) begin
			// Byte as seen before this read clears the ready flag
			r_next.chan = data_read_chan;
			r_next.status = tap.status_bytes[data_read_chan]; // [RQ11]
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign status_out_valid = r_reg.valid;
	assign status_out_chan = r_reg.chan;
	assign status_out = r_reg.status;
endmodule : acsr_status_tap

// File: rtl/acsr_bank.sv
// Channel calibration, status and setup register bank with AHB-Lite slave
// Summary of operation
// RQ1 - Eight 24-bit read/write full-scale coefficients at 0x18-0x1F, reset 0x200000.
// RQ2 - Full-scale calibration end overwrites coefficient; coefficient goes to scaling logic.
// RQ3 - Coefficient writes only take effect in idle mode; host writes only then.
// RQ4 - Eight read-only status registers 0x20-0x27, reset to channel times 0x20.
// RQ5 - Status bits 7-5 always return the register's channel number.
// RQ6 - Status bit 4 is zero, or pin zero level when option set.
// RQ7 - Status bit 3 is channel ready, or pin one level when option set.
// RQ8 - Status bit 2 set when conversion runs with reference below threshold.
// RQ9 - Status bit 1 gives input polarity: zero positive, one negative.
// RQ10 - Status bit 0 set on over-range or under-range input.
// RQ11 - Continuous read sends the channel status with every data transfer.
// RQ12 - Dump mode may optionally pair the status read with data read.
// RQ13 - Eight read/write setup registers at 0x28-0x2F, reset 0x00.
// RQ14 - Setup fields: buffer off, input config, status option, enable, range.
// RQ15 - Input buffer enabled while buffer-disable bit is zero.
// RQ16 - Config 00 single-ended to common; 11 selects fixed differential pairs.
// RQ17 - Ready set when conversion updates data, cleared when data is read.
// RQ18 - Sign, over-range and no-reference latch together with the data update.
`timescale 1ns/1ns
module acsr_bank (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic [1:0] hresp,
	input wire logic conv_idle,
	input wire logic [acsr_pkg::NUM_CH-1:0] conv_done,
	input wire logic conv_sign,
	input wire logic conv_ovr,
	input wire logic ref_below_thr,
	input wire logic cal_fs_done,
	input wire logic [2:0] cal_chan,
	input wire logic [acsr_pkg::FS_W-1:0] cal_coeff,
	input wire logic [2:0] coeff_chan,
	output logic [acsr_pkg::FS_W-1:0] coeff_fs_out,
	input wire logic data_read,
	input wire logic [2:0] data_read_chan,
	input wire logic cont_read_mode,
	input wire logic dump_status_en,
	input wire logic gpio_pin_zero,
	input wire logic gpio_pin_one,
	output logic [acsr_pkg::NUM_CH-1:0] buffer_enable,
	output logic [acsr_pkg::NUM_CH-1:0] chan_enable,
	output logic [acsr_pkg::NUM_CH-1:0] status_option,
	output logic [acsr_pkg::NUM_CH-1:0][2:0] range_select,
	output logic [acsr_pkg::NUM_CH-1:0][2:0] mux_pos,
	output logic [acsr_pkg::NUM_CH-1:0][2:0] mux_neg,
	output logic [acsr_pkg::NUM_CH-1:0] mux_common,
	output logic status_out_valid,
	output logic [2:0] status_out_chan,
	output logic [7:0] status_out,
	output logic irq
);
	acsr_pkg::acsr_bank_s r_reg;
	acsr_pkg::acsr_bank_s r_next;

	acsr_tap_if tap_bus ();

	// Assemble one status byte from a given register image
	function automatic logic [7:0] stat_byte(
		input acsr_pkg::acsr_bank_s s,
		input logic [2:0] ch
	);
		logic [7:0] b;
		logic opt;
		b = '0;
		opt = s.setup[ch][acsr_pkg::SU_STATUS_OPTION];
		b[7:acsr_pkg::ST_CHAN_LSB] = ch; // [RQ4] [RQ5]
		b[acsr_pkg::ST_GPIO0] = opt & s.gpio0; // [RQ6]
		b[acsr_pkg::ST_READY] = opt ? s.gpio1 : s.ready[ch]; // [RQ7]
		b[acsr_pkg::ST_MISSING_REFERENCE_FLAG] = s.missing_reference_flag[ch]; // [RQ8]
		b[acsr_pkg::ST_SIGN] = s.sign[ch]; // [RQ9]
		b[acsr_pkg::ST_OVR] = s.out_of_range_flag[ch]; // [RQ10]
		return b;
	endfunction : stat_byte

	// Word read mux over the register image
	function automatic logic [31:0] read_word(
		input acsr_pkg::acsr_bank_s s,
		input logic [7:0] idx
	);
		logic [31:0] w;
		w = '0;
		if (idx[7:3] == acsr_pkg::IDX_FS_BASE[7:3]) begin
			w[acsr_pkg::FS_W-1:0] = s.fs[idx[2:0]]; // [RQ1]
		end else if (idx[7:3] == acsr_pkg::IDX_STAT_BASE[7:3]) begin
			w[7:0] = stat_byte(s, idx[2:0]); // [RQ4]
		end else if (idx[7:3] == acsr_pkg::IDX_SETUP_BASE[7:3]) begin
			w[7:0] = s.setup[idx[2:0]]; // [RQ13]
		end else if (idx == acsr_pkg::IDX_INT_STAT) begin
			w[acsr_pkg::INT_W-1:0] = s.int_stat;
		end else if (idx == acsr_pkg::IDX_INT_MASK) begin
			w[acsr_pkg::INT_W-1:0] = s.int_mask;
		end
		return w;
	endfunction : read_word

	logic accept;
	logic [7:0] acc_idx;
	logic [acsr_pkg::INT_W-1:0] int_events;
	logic any_conv;

	always_comb begin
		r_next = r_reg;
		accept = hsel & hready & htrans[1];
		acc_idx = haddr[9:2];
		any_conv = |conv_done;

		// Pins pass three stages; a change counts once stages two and three agree
		r_next.g0_sync = {r_reg.g0_sync[1:0], gpio_pin_zero};
		r_next.g1_sync = {r_reg.g1_sync[1:0], gpio_pin_one};
		if (r_reg.g0_sync[1] == r_reg.g0_sync[2]) begin
			r_next.gpio0 = r_reg.g0_sync[2]; // [RQ6]
		end
		if (r_reg.g1_sync[1] == r_reg.g1_sync[2]) begin
			r_next.gpio1 = r_reg.g1_sync[2]; // [RQ7]
		end

		// Data phase of a write taken in the previous cycle
		if (r_reg.wr_pend) begin
			if (r_reg.wr_idx[7:3] == acsr_pkg::IDX_FS_BASE[7:3]) begin
				// Outside idle the write is dropped so a running scale stays intact
				if (conv_idle) begin
					r_next.fs[r_reg.wr_idx[2:0]] = hwdata[acsr_pkg::FS_W-1:0]; // [RQ1] [RQ3]
				end
			end else if (r_reg.wr_idx[7:3] == acsr_pkg::IDX_SETUP_BASE[7:3]) begin
				r_next.setup[r_reg.wr_idx[2:0]] = hwdata[7:0]; // [RQ13] [RQ14]
			end else if (r_reg.wr_idx == acsr_pkg::IDX_INT_STAT) begin
				r_next.int_stat = r_reg.int_stat & ~hwdata[acsr_pkg::INT_W-1:0];
			end else if (r_reg.wr_idx == acsr_pkg::IDX_INT_MASK) begin
				r_next.int_mask = hwdata[acsr_pkg::INT_W-1:0];
			end
		end

		// Calibration result wins over a host write in the same cycle
		if (cal_fs_done) begin
			r_next.fs[cal_chan] = cal_coeff; // [RQ2]
		end

		// Per-channel result flags and ready
		for (int i = 0; i < acsr_pkg::NUM_CH; i++) begin
			if (conv_done[i]) begin
				// New result: ready set wins over a read clear in the same cycle
				r_next.ready[i] = 1'b1; // [RQ17]
				r_next.sign[i] = conv_sign; // [RQ9] [RQ18]
				r_next.out_of_range_flag[i] = conv_ovr; // [RQ10] [RQ18]
				r_next.missing_reference_flag[i] = ref_below_thr; // [RQ8] [RQ18]
			end else if (data_read && (data_read_chan == 3'(i))) begin
				r_next.ready[i] = 1'b0; // [RQ17]
			end
		end

		// Sticky events; a set beats a write-one clear in the same cycle
		int_events = '0;
		int_events[acsr_pkg::INT_CONV_LSB +: acsr_pkg::NUM_CH] = conv_done;
		int_events[acsr_pkg::INT_MISSING_REFERENCE_FLAG] = any_conv & ref_below_thr;
		int_events[acsr_pkg::INT_OVR] = any_conv & conv_ovr;
		int_events[acsr_pkg::INT_CAL] = cal_fs_done;
		r_next.int_stat = r_next.int_stat | int_events;

		// Input routing and coefficient selection follow the updated image
		for (int i = 0; i < acsr_pkg::NUM_CH; i++) begin
			if (r_next.setup[i][acsr_pkg::SU_CFG_HI:acsr_pkg::SU_CFG_LO] == acsr_pkg::CFG_DIFF) begin
				r_next.mux_pos[i] = {i[1:0], 1'b0}; // [RQ16]
				r_next.mux_neg[i] = {i[1:0], 1'b1}; // [RQ16]
				r_next.mux_common[i] = 1'b0;
			end else begin
				// Codes 01 and 10 fall back to single-ended
				r_next.mux_pos[i] = 3'(i); // [RQ16]
				r_next.mux_neg[i] = 3'(i);
				r_next.mux_common[i] = 1'b1; // [RQ16]
			end
		end
		r_next.fs_sel = r_next.fs[coeff_chan]; // [RQ2]

		// Address phase: remember writes, fetch reads from the updated image
		r_next.wr_pend = accept & hwrite;
		r_next.wr_idx = acc_idx;
		if (accept && !hwrite) begin
			r_next.rdata = read_word(r_next, acc_idx);
		end else begin
			r_next.rdata = '0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r_reg <= acsr_pkg::BANK_RESET;
		end else begin
			r_reg <= r_next;
		end
	end

	// Live status bytes for the transfer tap and per-channel setup field outputs
	for (genvar g = 0; g < acsr_pkg::NUM_CH; g++) begin : g_stat
		assign tap_bus.status_bytes[g] = stat_byte(r_reg, 3'(g)); // [RQ5]
		assign buffer_enable[g] = ~r_reg.setup[g][acsr_pkg::SU_BUF_OFF]; // [RQ15]
		assign chan_enable[g] = r_reg.setup[g][acsr_pkg::SU_ENABLE]; // [RQ14]
		assign status_option[g] = r_reg.setup[g][acsr_pkg::SU_STATUS_OPTION]; // [RQ14]
		assign range_select[g] =
			r_reg.setup[g][acsr_pkg::SU_RANGE_MSB:acsr_pkg::SU_RANGE_LSB]; // [RQ14]
	end

	acsr_status_tap u_tap (
		.hclk(hclk),
		.hresetn(hresetn),
		.tap(tap_bus.tap),
		.data_read(data_read),
		.data_read_chan(data_read_chan),
		.cont_read_mode(cont_read_mode),
		.dump_status_en(dump_status_en),
		.status_out_valid(status_out_valid),
		.status_out_chan(status_out_chan),
		.status_out(status_out)
	);

	// Zero wait states; every transfer answers OKAY
	assign hreadyout = 1'b1;
	assign hresp = acsr_pkg::HRESP_OKAY;
	assign hrdata = r_reg.rdata;
	assign coeff_fs_out = r_reg.fs_sel;
	assign mux_pos = r_reg.mux_pos;
	assign mux_neg = r_reg.mux_neg;
	assign mux_common = r_reg.mux_common;
	assign irq = |(r_reg.int_stat & r_reg.int_mask);
endmodule : acsr_bank

// File: tb/acsr_core_model.sv
// Converter core model that posts per-channel conversion results
`timescale 1ns/1ns
module acsr_core_model (
	input wire logic hclk,
	input wire logic start,
	input wire logic [2:0] chan,
	input wire logic [2:0] flags,
	input wire logic [3:0] lat,
	output logic [acsr_pkg::NUM_CH-1:0] conv_done,
	output logic conv_sign,
	output logic conv_ovr,
	output logic ref_below_thr
);
	int cnt = -1;
	logic [2:0] ch_q;
	logic [2:0] fl_q;
	// Flags toggle outside the pulse so a stale level never passes as a result
	always @(posedge hclk) begin
		conv_done <= '0;
		{conv_sign, conv_ovr, ref_below_thr} <= ~{conv_sign, conv_ovr, ref_below_thr};
		if (start) begin
			cnt <= int'(lat);
			ch_q <= chan;
			fl_q <= flags;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end else if (cnt == 0) begin
			conv_done[ch_q] <= 1'b1;
			{conv_sign, conv_ovr, ref_below_thr} <= fl_q;
			cnt <= -1;
		end
	end
endmodule : acsr_core_model

// File: tb/acsr_bank_asserts.sv
// Checker of the channel register bank ports
`timescale 1ns/1ns
module acsr_bank_asserts (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic [1:0] hresp,
	input wire logic conv_idle,
	input wire logic cal_fs_done,
	input wire logic [2:0] cal_chan,
	input wire logic [acsr_pkg::FS_W-1:0] cal_coeff,
	input wire logic [2:0] coeff_chan,
	input wire logic [acsr_pkg::FS_W-1:0] coeff_fs_out,
	input wire logic data_read,
	input wire logic [2:0] data_read_chan,
	input wire logic cont_read_mode,
	input wire logic dump_status_en,
	input wire logic [acsr_pkg::NUM_CH-1:0] status_option,
	input wire logic status_out_valid,
	input wire logic [2:0] status_out_chan,
	input wire logic [7:0] status_out
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic tap;
	logic rd_go;
	assign tap = data_read && (cont_read_mode || dump_status_en);
	assign rd_go = hsel && hready && htrans[1] && !hwrite;
	AST_BUS_OK: assert property (hreadyout && hresp == acsr_pkg::HRESP_OKAY)
		else $error("bus slave not ready or not okay");
	AST_RDATA_IDLE: assert property (!rd_go |=> hrdata == 32'h0000_0000)
		else $error("read data outside a read data phase");
	AST_STAT_CHAN: assert property (rd_go && haddr[9:5] == 5'h04 |=>
		hrdata[31:5] == {24'h00_0000, $past(haddr[4:2])}) else $error("status index wrong");
	AST_TAP_PULSE: assert property (tap |=> status_out_valid &&
		status_out_chan == $past(data_read_chan)) else $error("status not sent with data");
	AST_TAP_QUIET: assert property (!tap |=> !status_out_valid)
		else $error("status sent without data read");
	AST_TAP_OPT0: assert property (tap && !status_option[data_read_chan] |=> !status_out[4])
		else $error("pin zero bit set without option");
	AST_CAL_LOAD: assert property (cal_fs_done && coeff_chan == cal_chan |=>
		coeff_fs_out == $past(cal_coeff)) else $error("calibration coefficient not loaded");
	AST_COEFF_HOLD: assert property ($past(hresetn) && !cal_fs_done && !conv_idle &&
		$stable(coeff_chan) |=> $stable(coeff_fs_out)) else $error("coefficient changed in run");
	COV_TAP: cover property (tap);
	COV_CAL: cover property (cal_fs_done);
	COV_STAT_READ: cover property (rd_go && haddr[9:5] == 5'h04);
endmodule : acsr_bank_asserts

bind acsr_bank acsr_bank_asserts u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hready, .hreadyout, .hrdata, .hresp, .conv_idle, .cal_fs_done, .cal_chan, .cal_coeff,
	.coeff_chan, .coeff_fs_out, .data_read, .data_read_chan, .cont_read_mode,
	.dump_status_en, .status_option, .status_out_valid, .status_out_chan, .status_out);

// File: tb/acsr_bank_tb_top.sv
// Self-checking bench of the channel register bank
`timescale 1ns/1ns
module acsr_bank_tb_top;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, conv_idle, cal_fs_done, irq;
	logic data_read, cont_read_mode, dump_status_en, gpio_pin_zero, gpio_pin_one, start;
	logic status_out_valid, conv_sign, conv_ovr, ref_below_thr;
	logic [1:0] htrans, hresp;
	logic [2:0] hsize, cal_chan, coeff_chan, data_read_chan, status_out_chan, c, f;
	logic [3:0] lat;
	logic [7:0] conv_done, buffer_enable, chan_enable, status_option, mux_common, status_out, v;
	logic [7:0][2:0] range_select, mux_pos, mux_neg;
	logic [23:0] cal_coeff, coeff_fs_out;
	logic [31:0] haddr, hwdata, hrdata, rd_q, d, e, ie;
	int errors, comparisons, seed;
	assign hready = hreadyout;
	acsr_bank DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
		.hreadyout, .hrdata, .hresp, .conv_idle, .conv_done, .conv_sign, .conv_ovr,
		.ref_below_thr, .cal_fs_done, .cal_chan, .cal_coeff, .coeff_chan, .coeff_fs_out,
		.data_read, .data_read_chan, .cont_read_mode, .dump_status_en, .gpio_pin_zero,
		.gpio_pin_one, .buffer_enable, .chan_enable, .status_option, .range_select, .mux_pos,
		.mux_neg, .mux_common, .status_out_valid, .status_out_chan, .status_out, .irq);
	acsr_core_model u_core (.hclk, .start, .chan(c), .flags(f), .lat, .conv_done, .conv_sign,
		.conv_ovr, .ref_below_thr);
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	always @(posedge hclk) rd_q <= hrdata;
	task automatic report_and_stop;
		if (errors == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : report_and_stop
	task automatic hang;
		errors++;
		report_and_stop();
	endtask : hang
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		comparisons++;
		if (got !== ex) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk
	// Slave answers at once today, but the bounded wait keeps a stall from hanging
	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 20);
		if (hready !== 1'b1) hang();
	endtask : wait_rdy
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= acsr_pkg::HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		#1 d = rd_q;
	endtask : bus
	task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] ex);
		bus(1'b0, a, '0);
		chk(nm, ex, d);
	endtask : rdc
	// Group 0 coefficients, 1 status, 2 setup
	function automatic logic [31:0] ad(input int g, input logic [2:0] ch);
		return {22'h0, acsr_pkg::IDX_FS_BASE + 8'h08 * 8'(g) + 8'(ch), 2'b00};
	endfunction : ad
	initial begin
		{hresetn, hsel, hwrite, conv_idle, cal_fs_done, data_read, start} = '0;
		{cont_read_mode, dump_status_en, gpio_pin_zero, gpio_pin_one} = '0;
		{htrans, haddr, hwdata, cal_chan, cal_coeff, coeff_chan, data_read_chan, c, f, lat} = '0;
		hsize = 3'h2;
		{errors, comparisons, seed, ie} = {32'h0, 32'h0, 32'h0000_470D, 32'h0000_0400};
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			c = 3'(i);
			bus(1'b1, ad(1, c), 32'hFFFF_FFFF);
			rdc("status", ad(1, c), {24'h0, c, 5'h00});
			rdc("fs", ad(0, c), 32'h0020_0000);
			rdc("setup", ad(2, c), '0);
		end
		rdc("unmapped", 32'h0000_0200, '0);
		for (int i = 0; i < 8; i++) begin
			c = 3'(i);
			v = 8'($random(seed));
			if (i == 4) v[6:5] = acsr_pkg::CFG_DIFF;
			bus(1'b1, ad(2, c), {24'h0, v});
			rdc("setup", ad(2, c), {24'h0, v});
			chk("fields", {26'h0, ~v[7], v[4:0]}, {26'h0, buffer_enable[c], status_option[c],
				chan_enable[c], range_select[c]});
			e = (v[6:5] == acsr_pkg::CFG_DIFF) ? {26'h0, c[1:0], 1'b0, c[1:0], 1'b1} :
				{25'h0, 1'b1, c, 3'h0};
			// Negative leg is a don't-care while the common input is selected
			d = {25'h0, mux_common[c], mux_pos[c], mux_common[c] ? 3'h0 : mux_neg[c]};
			chk("mux", e, d);
		end
		c = 3'($random(seed));
		e = 32'($random(seed)) & 32'h00FF_FFFF;
		coeff_chan <= c;
		conv_idle <= 1'b1;
		bus(1'b1, ad(0, c), e);
		conv_idle <= 1'b0;
		bus(1'b1, ad(0, c), ~e);
		rdc("fs_idle", ad(0, c), e);
		chk("coeff_out", e, {8'h00, coeff_fs_out});
		@(posedge hclk);
		cal_fs_done <= 1'b1;
		cal_chan <= c;
		cal_coeff <= ~e[23:0];
		@(posedge hclk);
		cal_fs_done <= 1'b0;
		rdc("fs_cal", ad(0, c), {8'h00, ~e[23:0]});
		for (int k = 0; k < 2; k++) begin
			c = 3'($random(seed));
			f = 3'($random(seed));
			ie = ie | {22'h0, f[1], f[0], 8'h01 << c};
			bus(1'b1, ad(2, c), '0);
			start <= 1'b1;
			lat <= k[0] ? 4'h9 : 4'h0;
			@(posedge hclk);
			start <= 1'b0;
			for (int n = 0; conv_done[c] !== 1'b1; n++) begin
				if (n > 20) hang();
				@(posedge hclk);
			end
			e = {24'h0, c, 2'b01, f[0], f[2], f[1]};
			rdc("status_conv", ad(1, c), e);
			data_read <= 1'b1;
			data_read_chan <= c;
			cont_read_mode <= k[0];
			dump_status_en <= !k[0];
			@(posedge hclk);
			data_read <= 1'b0;
			#1 d = {20'h0, status_out_valid, status_out_chan, status_out};
			chk("tap", {20'h0, 1'b1, c, e[7:0]}, d);
			rdc("ready_clear", ad(1, c), e & 32'hFFFF_FFF7);
		end
		chk("irq_masked", '0, {31'h0, irq});
		rdc("int_stat", 32'h0000_0100, ie);
		bus(1'b1, 32'h0000_0104, ie);
		rdc("int_mask", 32'h0000_0104, ie);
		chk("irq", 32'h0000_0001, {31'h0, irq});
		bus(1'b1, 32'h0000_0100, ie);
		rdc("int_clear", 32'h0000_0100, '0);
		chk("irq_clear", '0, {31'h0, irq});
		bus(1'b1, ad(2, c), 32'h0000_0010);
		for (int k = 0; k < 4; k++) begin
			gpio_pin_zero <= k[0];
			gpio_pin_one <= k[1];
			repeat (6) @(posedge hclk);
			rdc("status_pins", ad(1, c), {24'h0, c, k[0], k[1], e[2:0]});
		end
		// Mid-run reset must restore routing, coefficient tap and latched flags
		@(posedge hclk);
		hresetn <= 1'b0;
		@(posedge hclk);
		#1 chk("mux_rst", {29'h0, c}, {29'h0, mux_pos[c]});
		chk("coeff_rst", 32'h0020_0000, {8'h00, coeff_fs_out});
		@(posedge hclk);
		hresetn <= 1'b1;
		rdc("fs_rst", ad(0, c), 32'h0020_0000);
		rdc("status_rst", ad(1, c), {24'h0, c, 5'h00});
		chk("irq_rst", '0, {31'h0, irq});
		report_and_stop();
	end
endmodule : acsr_bank_tb_top
